// *** acg_params.svh ***
// Constants for the converter configuration link and its controller
// Overview of operation
// - Pseudo bit selects eight pseudo differential inputs
// - Enabled channels are converted in turn
// - Each channel waits full settling time
// - Host enables one channel for calibration
// - Burnout bit switches signal-path current sources
// - Burnout only with buffer on, chop off
// - Reference detect sets reference missing flag
// - Detection updates only while converting
// - Host always writes zero to bit five
// - Buffer bit inserts the input buffer
// - Polarity bit selects unipolar or bipolar
// - Host gain field sets gain and range
// - Chop bit enables offset chopping
`ifndef ACG_PARAMS_SVH
`define ACG_PARAMS_SVH
`define ACG_CFG_W            24
`define ACG_CHOP_BIT         23
`define ACG_PSEUDO_BIT       18
`define ACG_CH_HI            17
`define ACG_CH_LO            8
`define ACG_BURN_BIT         7
`define ACG_REFERENCE_LOSS_DETECT_ENABLE_BIT       6
`define ACG_ZERO_BIT         5
`define ACG_BUF_BIT          4
`define ACG_UB_BIT           3
`define ACG_GAIN_HI          2
`define ACG_GAIN_LO          0
`define ACG_CFG_RESET        24'h000117
`define ACG_CLK_PERIOD_NS    8
`define ACG_SETTLE_NS        80000000
`define ACG_SETTLE_CHOP_NS   160000000
`define ACG_SETTLE_CYC       ((`ACG_SETTLE_NS + `ACG_CLK_PERIOD_NS - 1) / `ACG_CLK_PERIOD_NS)
`define ACG_SETTLE_CHOP_CYC  ((`ACG_SETTLE_CHOP_NS + `ACG_CLK_PERIOD_NS - 1) / `ACG_CLK_PERIOD_NS)
`define ACG_OFS_CFG          8'h00
`define ACG_OFS_CTRL         8'h04
`define ACG_OFS_STATUS       8'h08
`define ACG_OFS_READBACK     8'h0C
`define ACG_OFS_INT_STATUS   8'h10
`define ACG_OFS_INT_MASK     8'h14
`define ACG_CTRL_WR_BIT      0
`define ACG_CTRL_RD_BIT      1
`define ACG_CTRL_RUN_BIT     2
`define ACG_ST_BUSY_BIT      0
`define ACG_ST_RUN_BIT       1
`define ACG_ST_REF_BIT       2
`define ACG_ST_ONE_CH_BIT    3
`define ACG_EV_RESULT_BIT    0
`define ACG_EV_REF_BIT       1
`define ACG_EV_RDBK_BIT      2
`define ACG_EV_W             3
`define ACG_RESP_OKAY        2'h0
`define ACG_RESP_SLVERR      2'h2
`endif

// *** acg_pkg.sv ***
// Types shared by both ends of the configuration link
`include "acg_params.svh"
package acg_pkg;
	typedef enum logic {ACG_IDLE, ACG_SETTLE} acg_seq_t;
	typedef logic [`ACG_CFG_W-1:0] acg_cfg_t;
endpackage

// *** acg_if.sv ***
// Link between the configuration controller and the converter control logic
`timescale 1ns/1ns
`include "acg_params.svh"
interface acg_if;
	logic             cfg_wr;
	logic             cfg_rd;
	acg_pkg::acg_cfg_t cfg_wdata;
	acg_pkg::acg_cfg_t cfg_rdata;
	logic             cfg_rvalid;
	logic             conv_run;
	logic             ref_missing;
	logic             result_strobe;
	logic [3:0]       result_channel;

	modport device (
		input  cfg_wr,
		input  cfg_rd,
		input  cfg_wdata,
		input  conv_run,
		output cfg_rdata,
		output cfg_rvalid,
		output ref_missing,
		output result_strobe,
		output result_channel
	);

	modport host (
		output cfg_wr,
		output cfg_rd,
		output cfg_wdata,
		output conv_run,
		input  cfg_rdata,
		input  cfg_rvalid,
		input  ref_missing,
		input  result_strobe,
		input  result_channel
	);
endinterface

// *** acg_device.sv ***
// Converter configuration register, channel sequencer and reference detect
`timescale 1ns/1ns
`include "acg_params.svh"
module acg_device #(
	parameter int unsigned SETTLE_CYC      = `ACG_SETTLE_CYC,
	parameter int unsigned SETTLE_CHOP_CYC = `ACG_SETTLE_CHOP_CYC
) (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	acg_if.device           link,
	input  wire logic       ref_low_pin,
	output logic            pseudo_mode,
	output logic            buffer_en,
	output logic            burnout_en,
	output logic            chop_en,
	output logic            unipolar,
	output logic [2:0]      gain_select,
	output logic [9:0]      channel_enable,
	output logic [3:0]      active_channel,
	output logic            conv_active,
	output logic            gain_reserved
);
	localparam int CNT_W = 25;
	localparam int NCH   = `ACG_CH_HI - `ACG_CH_LO + 1;

	// Next enabled channel after cur, wrapping; cur kept when none enabled
	function automatic logic [3:0] acg_next_ch(
		input logic [NCH-1:0] en,
		input logic [3:0]     cur
	);
		logic [3:0] res;
		logic [3:0] idx;
		res = cur;
		for (int k = NCH; k >= 1; k--) begin
			idx = 4'((int'(cur) + k) % NCH);
			if (en[idx]) begin
				res = idx;
			end
		end
		return res;
	endfunction

	acg_pkg::acg_cfg_t   cfg;
	acg_pkg::acg_cfg_t   next_cfg;
	acg_pkg::acg_cfg_t   act;
	acg_pkg::acg_cfg_t   next_act;
	acg_pkg::acg_cfg_t   rdata;
	acg_pkg::acg_cfg_t   next_rdata;
	logic                rvalid;
	logic                next_rvalid;
	acg_pkg::acg_seq_t   state;
	acg_pkg::acg_seq_t   next_state;
	logic [CNT_W-1:0]    cnt;
	logic [CNT_W-1:0]    next_cnt;
	logic [CNT_W-1:0]    lim;
	logic [3:0]          ch;
	logic [3:0]          next_ch;
	logic                strobe;
	logic                next_strobe;
	logic [3:0]          res_ch;
	logic [3:0]          next_res_ch;
	logic [2:0]          sync;
	logic [2:0]          next_sync;
	logic                ref_flag;
	logic                next_ref_flag;
	logic                burn;
	logic                next_burn;
	logic                active;
	logic                next_active;
	logic                gres;
	logic                next_gres;
	logic [NCH-1:0]      en_cfg;

	assign en_cfg = cfg[`ACG_CH_HI:`ACG_CH_LO];

	// Chopped conversions need the longer settling time
	assign lim = act[`ACG_CHOP_BIT] ? CNT_W'(SETTLE_CHOP_CYC - 1) : CNT_W'(SETTLE_CYC - 1);

	// Register port
	always_comb begin
		next_cfg    = cfg;
		next_rdata  = rdata;
		next_rvalid = link.cfg_rd;
		if (link.cfg_wr) begin
			next_cfg = link.cfg_wdata;
		end
		if (link.cfg_rd) begin
			next_rdata = cfg;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg    <= `ACG_CFG_RESET;
			rdata  <= '0;
			rvalid <= 1'b0;
		end else begin
			cfg    <= next_cfg;
			rdata  <= next_rdata;
			rvalid <= next_rvalid;
		end
	end

	// Channel sequencer
	always_comb begin
		next_state  = state;
		next_act    = act;
		next_cnt    = cnt;
		next_ch     = ch;
		next_strobe = 1'b0;
		next_res_ch = res_ch;
		case (state)
			acg_pkg::ACG_IDLE: begin
				if (link.conv_run && |en_cfg) begin
					next_state = acg_pkg::ACG_SETTLE;
					next_act   = cfg;
					next_ch    = acg_next_ch(en_cfg, 4'(NCH - 1));
					next_cnt   = '0;
				end
			end
			acg_pkg::ACG_SETTLE: begin
				if (!link.conv_run) begin
					next_state = acg_pkg::ACG_IDLE;
				end else if (cnt == lim) begin
					next_strobe = 1'b1;
					next_res_ch = ch;
					next_cnt    = '0;
					if (|en_cfg) begin
						next_act = cfg;
						next_ch  = acg_next_ch(en_cfg, ch);
					end else begin
						next_state = acg_pkg::ACG_IDLE;
					end
				end else begin
					next_cnt = cnt + CNT_W'(1);
				end
			end
			default: begin
				next_state = acg_pkg::ACG_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state  <= acg_pkg::ACG_IDLE;
			act    <= `ACG_CFG_RESET;
			cnt    <= '0;
			ch     <= 4'h0;
			strobe <= 1'b0;
			res_ch <= 4'h0;
		end else begin
			state  <= next_state;
			act    <= next_act;
			cnt    <= next_cnt;
			ch     <= next_ch;
			strobe <= next_strobe;
			res_ch <= next_res_ch;
		end
	end

	// Reference detect; comparator pin is asynchronous
	always_comb begin
		next_sync     = {sync[1:0], ref_low_pin};
		next_ref_flag = ref_flag;
		if (!act[`ACG_REFERENCE_LOSS_DETECT_ENABLE_BIT]) begin
			next_ref_flag = 1'b0;
		end else if (state == acg_pkg::ACG_SETTLE && sync[1] == sync[2]) begin
			next_ref_flag = sync[2];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync     <= 3'h0;
			ref_flag <= 1'b0;
		end else begin
			sync     <= next_sync;
			ref_flag <= next_ref_flag;
		end
	end

	// Analog control levels derived from the applied configuration and the sequencer state
	always_comb begin
		next_burn   = next_act[`ACG_BURN_BIT] & next_act[`ACG_BUF_BIT] & ~next_act[`ACG_CHOP_BIT];
		next_active = (next_state == acg_pkg::ACG_SETTLE);
		next_gres   = (next_act[`ACG_GAIN_HI:`ACG_GAIN_LO] == 3'h1) ||
			(next_act[`ACG_GAIN_HI:`ACG_GAIN_LO] == 3'h2);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			burn   <= 1'b0;
			active <= 1'b0;
			gres   <= 1'b0;
		end else begin
			burn   <= next_burn;
			active <= next_active;
			gres   <= next_gres;
		end
	end

	assign pseudo_mode    = act[`ACG_PSEUDO_BIT];
	assign buffer_en      = act[`ACG_BUF_BIT];
	assign chop_en        = act[`ACG_CHOP_BIT];
	assign unipolar       = act[`ACG_UB_BIT];
	assign gain_select    = act[`ACG_GAIN_HI:`ACG_GAIN_LO];
	assign channel_enable = act[`ACG_CH_HI:`ACG_CH_LO];
	assign active_channel = ch;
	assign burnout_en     = burn;
	assign conv_active    = active;
	assign gain_reserved  = gres;

	assign link.cfg_rdata      = rdata;
	assign link.cfg_rvalid     = rvalid;
	assign link.ref_missing    = ref_flag;
	assign link.result_strobe  = strobe;
	assign link.result_channel = res_ch;
endmodule

// *** acg_host.sv ***
// AXI4-Lite controller that programs the converter configuration over the link
`timescale 1ns/1ns
`include "acg_params.svh"
module acg_host (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	output logic             irq,
	acg_if.host              link
);
	function automatic logic [31:0] acg_merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] m;
		m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		return (old & ~m) | (d & m);
	endfunction

	logic [7:0]              aw_q, next_aw_q;
	logic                    aw_ok, next_aw_ok;
	logic [31:0]             wd_q, next_wd_q;
	logic [3:0]              ws_q, next_ws_q;
	logic                    w_ok, next_w_ok;
	logic                    next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
	logic [1:0]              next_bresp, next_rresp;
	logic [31:0]             next_rdata, d;
	acg_pkg::acg_cfg_t       stage, next_stage, wdat, next_wdat, rdbk, next_rdbk;
	logic                    run, next_run, wr_p, next_wr_p, rd_p, next_rd_p;
	logic                    busy, next_busy, ref_prev, next_irq;
	logic [`ACG_EV_W-1:0]    ists, next_ists, imask, next_imask, ev;
	logic [3:0]              status;

	assign status = {($countones(stage[`ACG_CH_HI:`ACG_CH_LO]) == 1), link.ref_missing, run, busy};
	assign ev     = {link.cfg_rvalid, link.ref_missing & ~ref_prev, link.result_strobe};

	always_comb begin
		next_aw_q    = aw_q;
		next_aw_ok   = aw_ok;
		next_wd_q    = wd_q;
		next_ws_q    = ws_q;
		next_w_ok    = w_ok;
		next_bvalid  = bvalid;
		next_bresp   = bresp;
		next_arready = arready;
		next_rvalid  = rvalid;
		next_rresp   = rresp;
		next_rdata   = rdata;
		next_stage   = stage;
		next_wdat    = wdat;
		next_rdbk    = rdbk;
		next_run     = run;
		next_wr_p    = 1'b0;
		next_rd_p    = 1'b0;
		next_busy    = busy;
		next_ists    = ists | ev;
		next_imask   = imask;
		d            = 32'h0;
		if (awvalid && awready) begin
			next_aw_ok = 1'b1;
			next_aw_q  = awaddr;
		end
		if (wvalid && wready) begin
			next_w_ok = 1'b1;
			next_wd_q = wdata;
			next_ws_q = wstrb;
		end
		if (bvalid && bready) begin
			next_bvalid = 1'b0;
		end
		if (aw_ok && w_ok && !bvalid) begin
			next_aw_ok  = 1'b0;
			next_w_ok   = 1'b0;
			next_bvalid = 1'b1;
			next_bresp  = `ACG_RESP_OKAY;
			case (aw_q)
				`ACG_OFS_CFG: begin
					d          = acg_merge(32'(stage), wd_q, ws_q);
					next_stage = d[`ACG_CFG_W-1:0];
				end
				`ACG_OFS_CTRL: begin
					d = acg_merge({29'h0, run, 2'h0}, wd_q, ws_q);
					next_run = d[`ACG_CTRL_RUN_BIT];
					if (d[`ACG_CTRL_WR_BIT]) begin
						next_wr_p = 1'b1;
						next_wdat = stage;
						next_wdat[`ACG_ZERO_BIT] = 1'b0;
						next_wdat[`ACG_BURN_BIT] = stage[`ACG_BURN_BIT] & stage[`ACG_BUF_BIT] &
							~stage[`ACG_CHOP_BIT];
					end
					if (d[`ACG_CTRL_RD_BIT] && !busy) begin
						next_rd_p = 1'b1;
						next_busy = 1'b1;
					end
				end
				`ACG_OFS_INT_STATUS: begin
					d = acg_merge(32'h0, wd_q, ws_q);
					next_ists = (ists & ~d[`ACG_EV_W-1:0]) | ev;
				end
				`ACG_OFS_INT_MASK: begin
					d          = acg_merge(32'(imask), wd_q, ws_q);
					next_imask = d[`ACG_EV_W-1:0];
				end
				`ACG_OFS_STATUS, `ACG_OFS_READBACK: begin
					next_bresp = `ACG_RESP_OKAY;
				end
				default: begin
					next_bresp = `ACG_RESP_SLVERR;
				end
			endcase
		end
		if (link.cfg_rvalid) begin
			next_rdbk = link.cfg_rdata;
			next_busy = 1'b0;
		end
		if (rvalid && rready) begin
			next_rvalid  = 1'b0;
			next_arready = 1'b1;
		end
		if (arvalid && arready) begin
			next_arready = 1'b0;
			next_rvalid  = 1'b1;
			next_rresp   = `ACG_RESP_OKAY;
			case (araddr)
				`ACG_OFS_CFG:        next_rdata = 32'(stage);
				`ACG_OFS_CTRL:       next_rdata = {29'h0, run, 2'h0};
				`ACG_OFS_STATUS:     next_rdata = 32'(status);
				`ACG_OFS_READBACK:   next_rdata = 32'(rdbk);
				`ACG_OFS_INT_STATUS: next_rdata = 32'(ists);
				`ACG_OFS_INT_MASK:   next_rdata = 32'(imask);
				default: begin
					next_rdata = 32'h0;
					next_rresp = `ACG_RESP_SLVERR;
				end
			endcase
		end
		// Address channel reopens once no read is offered or pending
		if (!rvalid && !arvalid) begin
			next_arready = 1'b1;
		end
		next_awready = !next_aw_ok;
		next_wready  = !next_w_ok;
		next_irq     = |(next_ists & next_imask);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_q     <= 8'h00;
			aw_ok    <= 1'b0;
			wd_q     <= 32'h0;
			ws_q     <= 4'h0;
			w_ok     <= 1'b0;
			awready  <= 1'b0;
			wready   <= 1'b0;
			bvalid   <= 1'b0;
			bresp    <= `ACG_RESP_OKAY;
			arready  <= 1'b0;
			rvalid   <= 1'b0;
			rresp    <= `ACG_RESP_OKAY;
			rdata    <= 32'h0;
			stage    <= `ACG_CFG_RESET;
			wdat     <= `ACG_CFG_RESET;
			rdbk     <= '0;
			run      <= 1'b0;
			wr_p     <= 1'b0;
			rd_p     <= 1'b0;
			busy     <= 1'b0;
			ref_prev <= 1'b0;
			ists     <= '0;
			imask    <= '0;
			irq      <= 1'b0;
		end else begin
			aw_q     <= next_aw_q;
			aw_ok    <= next_aw_ok;
			wd_q     <= next_wd_q;
			ws_q     <= next_ws_q;
			w_ok     <= next_w_ok;
			awready  <= next_awready;
			wready   <= next_wready;
			bvalid   <= next_bvalid;
			bresp    <= next_bresp;
			arready  <= next_arready;
			rvalid   <= next_rvalid;
			rresp    <= next_rresp;
			rdata    <= next_rdata;
			stage    <= next_stage;
			wdat     <= next_wdat;
			rdbk     <= next_rdbk;
			run      <= next_run;
			wr_p     <= next_wr_p;
			rd_p     <= next_rd_p;
			busy     <= next_busy;
			ref_prev <= link.ref_missing;
			ists     <= next_ists;
			imask    <= next_imask;
			irq      <= next_irq;
		end
	end

	assign link.cfg_wr    = wr_p;
	assign link.cfg_rd    = rd_p;
	assign link.cfg_wdata = wdat;
	assign link.conv_run  = run;
endmodule

// *** acg_monitor.sv ***
// Checker watching the configuration link between the host and device ends
`timescale 1ns/1ns
`include "acg_params.svh"
module acg_monitor (
	input wire logic              aclk,
	input wire logic              aresetn,
	input wire logic              cfg_wr,
	input wire logic              cfg_rd,
	input wire acg_pkg::acg_cfg_t cfg_wdata,
	input wire acg_pkg::acg_cfg_t cfg_rdata,
	input wire logic              cfg_rvalid,
	input wire logic              conv_run,
	input wire logic              ref_missing,
	input wire logic              result_strobe,
	input wire logic [3:0]        result_channel
);
	acg_pkg::acg_cfg_t last_wr;
	acg_pkg::acg_cfg_t next_last_wr;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Shadow of the last word handed to the device
	always_comb begin
		next_last_wr = cfg_wr ? cfg_wdata : last_wr;
	end
	always_ff @(posedge aclk) begin
		last_wr <= aresetn ? next_last_wr : `ACG_CFG_RESET;
	end

	chk_rd_answer: assert property (cfg_rd |=> cfg_rvalid)
		else $error("read request not answered");
	chk_readback_value: assert property (cfg_rvalid |-> cfg_rdata == $past(last_wr))
		else $error("readback differs from last write");
	chk_zero_bit: assert property (cfg_wr |-> !cfg_wdata[`ACG_ZERO_BIT])
		else $error("bit five sent as one");
	chk_burn_gate: assert property (cfg_wr && cfg_wdata[`ACG_BURN_BIT]
		|-> cfg_wdata[`ACG_BUF_BIT] && !cfg_wdata[`ACG_CHOP_BIT])
		else $error("burnout sent without buffer or with chop");
	chk_settle_gap: assert property (result_strobe |=> !result_strobe [*7])
		else $error("results closer than settling time");
	chk_channel_range: assert property (result_strobe |-> result_channel <= 4'h9)
		else $error("result channel out of range");
	chk_channel_stands: assert property (!result_strobe |-> $stable(result_channel))
		else $error("result channel moved without strobe");
	chk_strobe_run: assert property (result_strobe |-> $past(conv_run))
		else $error("result while not running");
	chk_ref_idle_hold: assert property ((!conv_run) [*6] |=> $stable(ref_missing))
		else $error("reference flag moved while idle");

	cov_result: cover property (result_strobe);
	cov_readback: cover property (cfg_rvalid);
	cov_ref_rise: cover property ($rose(ref_missing));
endmodule

// *** adc_config_input_gain_control_bench.sv ***
// Self-checking bench joining the host and device ends of the configuration link
`timescale 1ns/1ns
`include "acg_params.svh"
module adc_config_input_gain_control_bench;
	logic              aclk = 0;
	logic              aresetn = 0;
	logic [7:0]        awaddr = 0;
	logic [7:0]        araddr = 0;
	logic [31:0]       wdata = 0;
	logic              awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, ref_low = 0;
	logic              awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0]        bresp, rresp, rs;
	logic [31:0]       rdata, rd;
	logic              pseudo_mode, buffer_en, burnout_en, chop_en, unipolar, conv_active, gain_reserved;
	logic [2:0]        gain_select;
	logic [9:0]        channel_enable;
	logic [3:0]        active_channel, ch;
	acg_pkg::acg_cfg_t cfg, cfg_s;
	int                failures = 0, total_checks = 0, cycles = 0, gap;
	int                exp_ch [2][4] = '{'{0, 2, 9, 0}, '{1, 1, 1, 1}};

	always #4 aclk = ~aclk;

	acg_if i_acg_if ();
	acg_host i_acg_host (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .irq(irq), .link(i_acg_if));
	acg_device #(.SETTLE_CYC(8), .SETTLE_CHOP_CYC(16)) i_acg_device (.aclk(aclk), .aresetn(aresetn),
		.link(i_acg_if), .ref_low_pin(ref_low), .pseudo_mode(pseudo_mode), .buffer_en(buffer_en),
		.burnout_en(burnout_en), .chop_en(chop_en), .unipolar(unipolar), .gain_select(gain_select),
		.channel_enable(channel_enable), .active_channel(active_channel), .conv_active(conv_active),
		.gain_reserved(gain_reserved));
	acg_monitor i_acg_monitor (.aclk(aclk), .aresetn(aresetn), .cfg_wr(i_acg_if.cfg_wr),
		.cfg_rd(i_acg_if.cfg_rd), .cfg_wdata(i_acg_if.cfg_wdata), .cfg_rdata(i_acg_if.cfg_rdata),
		.cfg_rvalid(i_acg_if.cfg_rvalid), .conv_run(i_acg_if.conv_run), .ref_missing(i_acg_if.ref_missing),
		.result_strobe(i_acg_if.result_strobe), .result_channel(i_acg_if.result_channel));

	task automatic stop_test;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			$display("[ERR] %0t timeout", $time);
			stop_test;
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_ok, w_ok;
		aw_ok = 0;
		w_ok = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (!aw_ok && awready === 1) begin
				aw_ok = 1;
				awvalid <= 0;
			end
			if (!w_ok && wready === 1) begin
				w_ok = 1;
				wvalid <= 0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1);
		rs = bresp;
		bready <= 0;
	endtask

	task automatic rdt(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do @(posedge aclk); while (arready !== 1);
		arvalid <= 0;
		do @(posedge aclk); while (rvalid !== 1);
		rd = rdata;
		rs = rresp;
		rready <= 0;
	endtask

	// Fetch the device's stored word through the read-go handshake
	task automatic readback;
		wr(`ACG_OFS_CTRL, 32'h2);
		rd = 0;
		for (int n = 0; n < 20 && rd[`ACG_EV_RDBK_BIT] !== 1; n++)
			rdt(`ACG_OFS_INT_STATUS);
		wr(`ACG_OFS_INT_STATUS, 32'h4);
		rdt(`ACG_OFS_READBACK);
	endtask

	task automatic push(input acg_pkg::acg_cfg_t c);
		wr(`ACG_OFS_CFG, {8'h00, c});
		wr(`ACG_OFS_CTRL, 32'h1);
	endtask

	// Wait for the next result and count the edges since the previous one
	task automatic strobe;
		gap = 0;
		do begin
			@(posedge aclk);
			gap++;
		end while (i_acg_if.result_strobe !== 1);
		ch = i_acg_if.result_channel;
	endtask

	function automatic acg_pkg::acg_cfg_t sent(input acg_pkg::acg_cfg_t c);
		sent = c;
		sent[`ACG_ZERO_BIT] = 1'b0;
		if (!c[`ACG_BUF_BIT] || c[`ACG_CHOP_BIT])
			sent[`ACG_BURN_BIT] = 1'b0;
	endfunction

	initial begin
		cfg = 24'($urandom(32'hB623));
		repeat (12) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		check(gain_select, 32'h7, "reset gain");
		check(buffer_en, 32'h1, "reset buffer");
		check(channel_enable, 32'h1, "reset channels");
		readback;
		check(rd, `ACG_CFG_RESET, "reset readback");
		wr(8'h20, 32'h1);
		check(rs, `ACG_RESP_SLVERR, "unmapped write");
		rdt(8'h20);
		check(rd, 32'h0, "unmapped read data");
		check(rs, `ACG_RESP_SLVERR, "unmapped read");
		$display("test reset done");
		for (int i = 0; i < 6; i++) begin
			cfg = (i == 0) ? 24'h0000B0 : (i == 1) ? 24'h8000B0 : 24'($urandom) & 24'h87FFFF;
			push(cfg);
			rdt(`ACG_OFS_STATUS);
			check(rd[`ACG_ST_ONE_CH_BIT], $countones(cfg[17:8]) == 1, "one channel");
			readback;
			check(rd, sent(cfg), "readback");
		end
		$display("test config done");
		for (int j = 0; j < 2; j++) begin
			cfg = j ? 24'h800292 : 24'h0605DB;
			cfg_s = sent(cfg);
			push(cfg);
			wr(`ACG_OFS_CTRL, 32'h4);
			for (int k = 0; k < 4; k++) begin
				strobe;
				if (k == 0) begin
					check({pseudo_mode, unipolar, buffer_en, chop_en, burnout_en, gain_select},
						{cfg[18], cfg[3], cfg[4], cfg[23], cfg_s[7], cfg[2:0]}, "applied");
					check(channel_enable, cfg[17:8], "applied channels");
					check(gain_reserved, cfg[2:0] == 3'h1 || cfg[2:0] == 3'h2, "reserved gain");
					check(conv_active, 32'h1, "converting");
				end
				if (k == 1) begin
					check(irq, j, "irq level");
					ref_low <= !j;
				end
				if (k < 3)
					check(active_channel, exp_ch[j][k + 1], "active channel");
				if (k == 3)
					check(gap, j ? 16 : 8, "settle gap");
				check(ch, exp_ch[j][k], "channel order");
			end
			rdt(`ACG_OFS_STATUS);
			check(rd[`ACG_ST_REF_BIT], !j, "ref flag");
			if (j == 0) begin
				wr(`ACG_OFS_INT_MASK, 32'h1);
				check(irq, 32'h1, "unmasked irq");
			end
			wr(`ACG_OFS_CTRL, 32'h0);
			ref_low <= 0;
			repeat (20) @(posedge aclk);
			check(conv_active, 32'h0, "idle");
			rdt(`ACG_OFS_STATUS);
			check(rd[`ACG_ST_REF_BIT], !j, "ref idle hold");
			wr(`ACG_OFS_INT_STATUS, 32'h7);
			rdt(`ACG_OFS_INT_STATUS);
			check({rd[`ACG_EV_RESULT_BIT], irq}, 32'h0, "irq cleared");
			$display("test run %0d done", j);
		end
		stop_test;
	end
endmodule
